//--- inc/eoc_map.vh
// Register map, field positions, reset values and timing counts of the external oscillator control block.
`ifndef EOC_MAP_VH
`define EOC_MAP_VH
`define EOC_ADDR_W 8
`define EOC_OFS_CONTROL 8'h9f
`define EOC_OFS_IRQ_STATUS 8'ha0
`define EOC_OFS_IRQ_MASK 8'ha1
`define EOC_OFS_VALID_TIME 8'ha2
`define EOC_VALID_BIT 7
`define EOC_MODE_HI 6
`define EOC_MODE_LO 4
`define EOC_FREQ_HI 2
`define EOC_FREQ_LO 0
`define EOC_CONTROL_RESET 8'h00
`define EOC_MODE_CMOS 3'h2
`define EOC_MODE_CMOS_DIV2 3'h3
`define EOC_MODE_RC 3'h4
`define EOC_MODE_CAP 3'h5
`define EOC_MODE_XTAL 3'h6
`define EOC_MODE_XTAL_DIV2 3'h7
`define EOC_IRQ_VALID_RISE 0
`define EOC_IRQ_VALID_LOSS 1
`define EOC_SETTLE_US 1000
`define EOC_CLK_MHZ 200
`define EOC_SETTLE_CYCLES (`EOC_SETTLE_US * `EOC_CLK_MHZ)
`define EOC_STABLE_EDGES 16'h0400
`endif

//--- hdl/eoc_sync2.v
// Two-stage synchroniser for one asynchronous level.
`timescale 1ns/1ps
module eoc_sync2
(
    // Clock and reset.
    input wire ref_clk,
    input wire rst,
    // Level in and out.
    input wire d,
    output reg q
);
    reg meta;
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            // Reset to the idle-high pin level, so the release of reset shows no false rising edge.
            meta <= 1'b1;
            q <= 1'b1;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

//--- hdl/eoc_ext_osc.v
// External oscillator control register, crystal qualification and clock output selection.
`timescale 1ns/1ps
`include "eoc_map.vh"
module eoc_ext_osc
#(
    parameter SETTLE_CYCLES = `EOC_SETTLE_CYCLES,
    parameter [15:0] STABLE_EDGES = `EOC_STABLE_EDGES
)
(
    // Clock and reset.
    input wire ref_clk,
    input wire rst,
    // Register port.
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // Oscillator pins and analog drive.
    input wire osc_pin_in,
    input wire osc_pin_out,
    output wire [2:0] ext_osc_mode_sel,
    output wire [2:0] ext_osc_freq_ctrl,
    output wire drive_enable,
    output wire crystal_enable,
    // Oscillator clock delivered to the clock tree, sampled in this domain.
    output reg osc_clk_out,
    output wire crystal_valid_flag,
    // Interrupt.
    output wire irq
);
    localparam ST_OFF = 3'b001;
    localparam ST_SETTLE = 3'b010;
    localparam ST_QUAL = 3'b100;

    reg [7:0] ext_osc_control;
    reg [1:0] irq_status;
    reg [1:0] irq_mask;
    reg [2:0] state;
    reg [2:0] next_state;
    reg [31:0] settle_cnt;
    reg [15:0] edge_cnt;
    reg valid;
    reg osc_q;
    reg div_tog;
    wire osc_in_s;
    wire osc_out_s;
    wire osc_s;
    wire osc_rise;
    wire xtal_mode;
    wire valid_rise;
    wire valid_loss;
    wire [2:0] mode;

    // Each pin has its own synchroniser, so the mode mux never sees a raw pin.
    eoc_sync2 u_sync_in
    (
        .ref_clk(ref_clk),
        .rst(rst),
        .d(osc_pin_in),
        .q(osc_in_s)
    );

    eoc_sync2 u_sync_out
    (
        .ref_clk(ref_clk),
        .rst(rst),
        .d(osc_pin_out),
        .q(osc_out_s)
    );

    // Crystal mode senses the input pin; all other modes take the clock on the output pin.
    assign osc_s = xtal_mode ? osc_in_s : osc_out_s;

    assign mode = ext_osc_control[`EOC_MODE_HI:`EOC_MODE_LO];
    assign ext_osc_mode_sel = mode;
    assign ext_osc_freq_ctrl = ext_osc_control[`EOC_FREQ_HI:`EOC_FREQ_LO];
    assign drive_enable = mode[2] | mode[1];
    assign xtal_mode = mode[2] & mode[1];
    assign crystal_enable = xtal_mode;
    assign osc_rise = osc_s & ~osc_q;
    assign crystal_valid_flag = valid;
    assign valid_rise = (next_state == ST_QUAL) && (edge_cnt == STABLE_EDGES - 16'h0001) && osc_rise && !valid;
    assign valid_loss = valid && !xtal_mode;
    assign irq = |(irq_status & irq_mask);

    // Register writes. Bit 3 and bit 7 are not stored by a write.
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            ext_osc_control <= `EOC_CONTROL_RESET;
            irq_mask <= 2'h0;
        end
        else if (reg_wr)
        begin
            if (reg_addr == `EOC_OFS_CONTROL)
            begin
                ext_osc_control <= {1'b0, reg_wdata[6:4], 1'b0, reg_wdata[2:0]};
            end
            if (reg_addr == `EOC_OFS_IRQ_MASK)
            begin
                irq_mask <= reg_wdata[1:0];
            end
        end
    end

    // Sticky status; a new event wins over a write-one clear in the same cycle.
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            irq_status <= 2'h0;
        end
        else
        begin
            irq_status <= (irq_status & ~((reg_wr && reg_addr == `EOC_OFS_IRQ_STATUS) ? reg_wdata[1:0] : 2'h0))
                | {valid_loss, valid_rise};
        end
    end

    // Qualification sequencer: bias settling time, then a run of oscillator edges.
    always @*
    begin
        next_state = state;
        case (state)
            ST_OFF:
            begin
                if (xtal_mode)
                begin
                    next_state = ST_SETTLE;
                end
            end
            ST_SETTLE:
            begin
                if (!xtal_mode)
                begin
                    next_state = ST_OFF;
                end
                else if (settle_cnt == SETTLE_CYCLES - 1)
                begin
                    next_state = ST_QUAL;
                end
            end
            ST_QUAL:
            begin
                if (!xtal_mode)
                begin
                    next_state = ST_OFF;
                end
            end
            default:
            begin
                next_state = ST_OFF;
            end
        endcase
    end

    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            state <= ST_OFF;
            settle_cnt <= 32'h0000_0000;
            edge_cnt <= 16'h0000;
            valid <= 1'b0;
            osc_q <= 1'b1;
        end
        else
        begin
            state <= next_state;
            osc_q <= osc_s;
            if (state == ST_SETTLE)
            begin
                settle_cnt <= settle_cnt + 32'h0000_0001;
            end
            else
            begin
                settle_cnt <= 32'h0000_0000;
            end
            if (next_state != ST_QUAL)
            begin
                edge_cnt <= 16'h0000;
                valid <= 1'b0;
            end
            else if (osc_rise && !valid)
            begin
                if (edge_cnt == STABLE_EDGES - 16'h0001)
                begin
                    valid <= 1'b1;
                end
                else
                begin
                    edge_cnt <= edge_cnt + 16'h0001;
                end
            end
        end
    end

    // Clock output: direct, halved in the divide modes, low when off.
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            div_tog <= 1'b0;
            osc_clk_out <= 1'b0;
        end
        else
        begin
            if (osc_rise)
            begin
                div_tog <= ~div_tog;
            end
            if (!drive_enable)
            begin
                osc_clk_out <= 1'b0;
            end
            else if (mode == `EOC_MODE_XTAL_DIV2 || mode == `EOC_MODE_CMOS_DIV2)
            begin
                osc_clk_out <= div_tog;
            end
            else
            begin
                osc_clk_out <= osc_s;
            end
        end
    end

    // Read data in the cycle after the strobe; unmapped addresses read zero.
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            reg_rdata <= 8'h00;
        end
        else if (reg_rd)
        begin
            case (reg_addr)
                `EOC_OFS_CONTROL: reg_rdata <= {valid, ext_osc_control[6:0]};
                `EOC_OFS_IRQ_STATUS: reg_rdata <= {6'h00, irq_status};
                `EOC_OFS_IRQ_MASK: reg_rdata <= {6'h00, irq_mask};
                default: reg_rdata <= 8'h00;
            endcase
        end
        else
        begin
            reg_rdata <= 8'h00;
        end
    end
endmodule

//--- tb/eoc_ext_osc_sva.sv
// Port checker for the external oscillator control block.
`timescale 1ns/1ps
module eoc_ext_osc_sva
(
    // Clock, reset and register port.
    input wire ref_clk,
    input wire rst,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    // Oscillator side.
    input wire [2:0] ext_osc_mode_sel,
    input wire [2:0] ext_osc_freq_ctrl,
    input wire drive_enable,
    input wire crystal_enable,
    input wire osc_clk_out,
    input wire crystal_valid_flag
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence ctl_wr;
        reg_wr && reg_addr == 8'h9f;
    endsequence
    sequence ctl_rd;
        reg_rd && reg_addr == 8'h9f;
    endsequence
    a_mode_write: assert property (ctl_wr |=> ext_osc_mode_sel == $past(reg_wdata[6:4]))
        else $error("mode not taken");
    a_freq_write: assert property (ctl_wr |=> ext_osc_freq_ctrl == $past(reg_wdata[2:0]))
        else $error("freq not taken");
    a_ctl_read: assert property (ctl_rd |=> reg_rdata == {$past(crystal_valid_flag),
        $past(ext_osc_mode_sel), 1'b0, $past(ext_osc_freq_ctrl)}) else $error("bad readback");
    a_valid_mode: assert property (!crystal_enable [*2] |-> !crystal_valid_flag)
        else $error("valid outside crystal");
    // The settle count is at least eight cycles in every build we run.
    a_valid_rise: assert property ($rose(crystal_valid_flag) |-> $past(crystal_enable, 8))
        else $error("valid too early");
    a_drive_decode: assert property (drive_enable == (ext_osc_mode_sel[2:1] != 2'b00))
        else $error("drive decode");
    a_xtal_decode: assert property (crystal_enable == (ext_osc_mode_sel[2:1] == 2'b11))
        else $error("crystal decode");
    a_clk_off: assert property (!drive_enable [*3] |-> !osc_clk_out)
        else $error("clock while off");
endmodule
bind eoc_ext_osc eoc_ext_osc_sva i_sva (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_osc_mode_sel(ext_osc_mode_sel), .ext_osc_freq_ctrl(ext_osc_freq_ctrl),
    .drive_enable(drive_enable), .crystal_enable(crystal_enable), .osc_clk_out(osc_clk_out),
    .crystal_valid_flag(crystal_valid_flag));

//--- tb/eoc_osc_model.sv
// Behavioural crystal feeding both oscillator pins.
`timescale 1ns/1ps
module eoc_osc_model
(
    // Run request.
    input wire run,
    // Pins.
    output logic pin_in,
    output logic pin_out
);
    logic osc = 1'b1;
    // Both pins rest high, so a stopped crystal gives no edges.
    always
    begin
        #17;
        osc = run ? ~osc : 1'b1;
    end
    assign pin_in = osc;
    assign pin_out = run ? ~osc : 1'b1;
endmodule

//--- tb/external_oscillator_control_test.sv
// Self-checking bench for the external oscillator control block.
`timescale 1ns/1ps
module external_oscillator_control_test;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic run = 1'b0;
    logic last = 1'b0;
    logic [7:0] got;
    wire [7:0] reg_rdata;
    wire [2:0] mode, freq;
    wire drv, xen, clk_out, valid, irq, pa, pb;
    int n_fail = 0;
    int num_checks = 0;
    int cyc = 0;
    int rises = 0;
    int n2;
    int n3;
    logic [7:0] rows [8][2] = '{'{8'h00, 8'h00}, '{8'h1f, 8'h17}, '{8'h2a, 8'h22}, '{8'h3b, 8'h33},
        '{8'h41, 8'h41}, '{8'h5e, 8'h56}, '{8'h6c, 8'h64}, '{8'hff, 8'h77}};
    eoc_ext_osc #(.SETTLE_CYCLES(20), .STABLE_EDGES(16'h0004)) i_dut (.ref_clk(ref_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .osc_pin_in(pa), .osc_pin_out(pb), .ext_osc_mode_sel(mode),
        .ext_osc_freq_ctrl(freq), .drive_enable(drv), .crystal_enable(xen), .osc_clk_out(clk_out),
        .crystal_valid_flag(valid), .irq(irq));
    eoc_osc_model i_osc (.run(run), .pin_in(pa), .pin_out(pb));
    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        cyc++;
        rises += (clk_out === 1'b1 && last === 1'b0);
        last <= clk_out;
        if (cyc == 6000)
        begin
            n_fail++;
            wrap_up();
        end
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(negedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        got = reg_rdata;
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        rd(8'h9f);
        chk("reset control", 8'h00, got);
        foreach (rows[i])
        begin
            wr(8'h9f, rows[i][0]);
            rd(8'h9f);
            chk("control", rows[i][1], got);
            chk("enables", {rows[i][1][6:5] != 2'b00, rows[i][1][6:5] == 2'b11}, {drv, xen});
            chk("mode pins", {1'b0, rows[i][1][6:4], 1'b0, rows[i][1][2:0]}, {1'b0, mode, 1'b0, freq});
        end
        rd(8'ha2);
        chk("unmapped", 8'h00, got);
        wr(8'h9f, 8'h00);
        wr(8'ha1, 8'h03);
        run <= 1'b1;
        wr(8'h9f, 8'h67);
        repeat (8) @(negedge ref_clk);
        chk("early valid", 8'h00, valid);
        repeat (12) @(negedge ref_clk);
        repeat (400) if (valid !== 1'b1) @(negedge ref_clk);
        rd(8'h9f);
        chk("valid read", 8'he7, got);
        chk("irq rise", 8'h01, irq);
        wr(8'h9f, 8'h70);
        rd(8'h9f);
        chk("lower freq", 8'hf0, got);
        n3 = rises;
        repeat (300) @(posedge ref_clk);
        n3 = rises - n3;
        wr(8'h9f, 8'h60);
        n2 = rises;
        repeat (300) @(posedge ref_clk);
        n2 = rises - n2;
        chk("crystal clock", 8'h01, n2 > 30);
        chk("halved", 8'h01, (n2 - 2 * n3) inside {[-2:2]});
        rd(8'ha0);
        chk("status rise", 8'h01, got);
        wr(8'ha0, 8'h01);
        chk("irq cleared", 8'h00, irq);
        wr(8'h9f, 8'h40);
        // The flag drops one edge after the mode leaves crystal; software ignores it there anyway.
        @(negedge ref_clk);
        chk("valid off", 8'h00, valid);
        chk("irq loss", 8'h01, irq);
        rd(8'ha0);
        chk("status loss", 8'h02, got);
        wr(8'ha1, 8'h00);
        chk("irq masked", 8'h00, irq);
        wr(8'h9f, 8'h20);
        n2 = rises;
        repeat (300) @(posedge ref_clk);
        n2 = rises - n2;
        wr(8'h9f, 8'h30);
        n3 = rises;
        repeat (300) @(posedge ref_clk);
        n3 = rises - n3;
        chk("cmos clock", 8'h01, n2 > 30);
        chk("cmos halved", 8'h01, (n2 - 2 * n3) inside {[-2:2]});
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        rd(8'h9f);
        chk("second reset", 8'h00, got);
        chk("reset clock", 8'h00, clk_out);
        wrap_up();
    end
endmodule
